// >>> trig_ctrl_regs.svh
// register offsets, field positions, reset values and codes for trigger control
`ifndef TRIG_CTRL_REGS_SVH
`define TRIG_CTRL_REGS_SVH

`define REG_VMODE       8'h00
`define REG_HMODE       8'h04
`define REG_SWTRIG      8'h08
`define REG_STATUS      8'h0C

`define VMODE_MODE_LSB  0
`define VMODE_ASSIGN_LSB 4
`define VMODE_APOL_BIT  6
`define VMODE_BPOL_BIT  7
`define VMODE_SEL_LSB   8
`define VMODE_CONA_BIT  12
`define VMODE_CONB_BIT  13

`define HMODE_MODE_LSB  0
`define HMODE_POL_BIT   2
`define HMODE_SEL_LSB   4

`define SEL_IGNORE      4'hF
`define VMODE_RESET     32'h0000_3000
`define HMODE_RESET     32'h0000_0000

`endif

// >>> trig_ctrl_pkg.sv
// types shared by the trigger control block
package trig_ctrl_pkg;

  typedef enum logic [3:0] {
    frame_free_run_mode             = 4'h0,
    acquire_command_mode            = 4'h1,
    acquire_command_start_stop_mode = 4'h2,
    frame_one_shot_mode             = 4'h3,
    frame_self_triggered_mode       = 4'h4,
    continuous_data_mode            = 4'h5,
    start_a_stop_b_mode             = 4'h6,
    start_a_stop_a_mode             = 4'h7,
    start_a_stop_a_level_mode       = 4'h8,
    qualified_continuous_mode       = 4'h9
  } frame_mode_t;

  typedef enum logic [1:0] {
    engines_shared_trigger      = 2'h0,
    engines_split_triggers      = 2'h1,
    first_triggered_second_free = 2'h2
  } assign_t;

  typedef enum logic [1:0] {
    line_free_run_mode       = 2'h0,
    line_one_shot_mode       = 2'h1,
    line_self_triggered_mode = 2'h2
  } line_mode_t;

  // frame source codes, extended variant included
  typedef enum logic [3:0] {
    src_diff       = 4'h0,
    src_ttl        = 4'h1,
    src_opto       = 4'h2,
    src_frame_valid = 4'h3,
    src_timing_gen = 4'h4,
    src_engine_zero_trig = 4'h5,
    src_button     = 4'h6,
    src_link_trig  = 4'h7,
    src_soft       = 4'h8,
    src_scan_step  = 4'h9,
    src_engine_zero_tgen = 4'hA
  } frame_src_t;

  // line encoder source codes
  typedef enum logic [3:0] {
    enc_ttl        = 4'h0,
    enc_diff       = 4'h1,
    enc_opto       = 4'h2,
    enc_engine_zero = 4'h3,
    enc_timing_gen = 4'h4,
    enc_button     = 4'h5,
    enc_link_trig  = 4'h6,
    software_encoder_source = 4'h7,
    enc_engine_zero_tgen = 4'h8
  } enc_src_t;

  // raw external inputs that travel together
  typedef struct packed {
    logic trig_diff;
    logic trig_ttl;
    logic trig_opto;
    logic frame_valid;
    logic timing_gen;
    logic engine_zero_trig;
    logic button;
    logic link_trig;
    logic scan_step;
    logic engine_zero_tgen;
    logic enc_ttl;
    logic enc_diff;
    logic enc_opto;
    logic engine_zero_enc;
    logic trig_second;
    logic qualifier;
  } ext_in_t;

endpackage

// >>> acquisition_trigger_control.sv
// frame and line trigger control with an axi4-lite register slave
`timescale 1ns/1ps
`include "trig_ctrl_regs.svh"

module acquisition_trigger_control #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire trig_ctrl_pkg::ext_in_t ext_in,
  input  wire logic                  frame_done,
  input  wire logic                  line_done,
  output logic                       frame_acquire_first,
  output logic                       frame_acquire_second,
  output logic                       frame_freeze,
  output logic                       data_accept,
  output logic                       line_acquire,
  output logic                       encoder_second_enable
);

  localparam int NIN = $bits(trig_ctrl_pkg::ext_in_t);

  // configuration registers
  logic [31:0] vmode_q;
  logic [31:0] hmode_q;
  logic [1:0]  soft_q;
  trig_ctrl_pkg::frame_mode_t mode;
  trig_ctrl_pkg::assign_t     asg;
  trig_ctrl_pkg::line_mode_t  lmode;
  logic [3:0] fsel;
  logic [3:0] esel;
  assign mode  = trig_ctrl_pkg::frame_mode_t'(vmode_q[`VMODE_MODE_LSB +: 4]);
  assign asg   = trig_ctrl_pkg::assign_t'(vmode_q[`VMODE_ASSIGN_LSB +: 2]);
  assign fsel  = vmode_q[`VMODE_SEL_LSB +: 4];
  assign lmode = trig_ctrl_pkg::line_mode_t'(hmode_q[`HMODE_MODE_LSB +: 2]);
  assign esel  = hmode_q[`HMODE_SEL_LSB +: 4];

  // two-stage synchroniser; stage one feeds only stage two
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= ext_in;
      sync2_q <= sync1_q;
    end
  end
  trig_ctrl_pkg::ext_in_t s;
  assign s = sync2_q;

  // frame source select
  logic hw_a;
  always_comb begin
    hw_a = 1'b0;
    case (fsel)
      trig_ctrl_pkg::src_diff:             hw_a = s.trig_diff;
      trig_ctrl_pkg::src_ttl:              hw_a = s.trig_ttl;
      trig_ctrl_pkg::src_opto:             hw_a = s.trig_opto;
      trig_ctrl_pkg::src_frame_valid:      hw_a = s.frame_valid;
      trig_ctrl_pkg::src_timing_gen:       hw_a = s.timing_gen;
      trig_ctrl_pkg::src_engine_zero_trig: hw_a = s.engine_zero_trig;
      trig_ctrl_pkg::src_button:           hw_a = s.button;
      trig_ctrl_pkg::src_link_trig:        hw_a = s.link_trig;
      trig_ctrl_pkg::src_soft:             hw_a = soft_q[0];
      trig_ctrl_pkg::src_scan_step:        hw_a = s.scan_step;
      trig_ctrl_pkg::src_engine_zero_tgen: hw_a = s.engine_zero_tgen;
      default:                             hw_a = 1'b0;
    endcase
  end

  // hardware gated by connect bits, soft always ored in
  logic trig_a_lvl;
  logic trig_b_lvl;
  logic a_asserted;
  logic b_asserted;
  assign trig_a_lvl = (hw_a & vmode_q[`VMODE_CONA_BIT]) | soft_q[0];
  assign trig_b_lvl = (s.trig_second & vmode_q[`VMODE_CONB_BIT]) | soft_q[1];
  assign a_asserted = trig_a_lvl ^ vmode_q[`VMODE_APOL_BIT];
  assign b_asserted = trig_b_lvl ^ vmode_q[`VMODE_BPOL_BIT];

  // edge detection on asserted level
  logic a_prev_q;
  logic b_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= a_asserted;
      b_prev_q <= b_asserted;
    end
  end
  logic a_rise;
  logic a_fall;
  logic b_rise;
  assign a_rise = a_asserted & ~a_prev_q;
  assign a_fall = ~a_asserted & a_prev_q;
  assign b_rise = b_asserted & ~b_prev_q;

  // frame engine state
  typedef enum logic [1:0] {fs_idle, fs_run, fs_frame, fs_freeze} fstate_t;
  fstate_t fst_q;
  logic    acq_first_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fst_q <= fs_idle;
    end else begin
      case (mode)
        trig_ctrl_pkg::frame_free_run_mode,
        trig_ctrl_pkg::frame_self_triggered_mode: fst_q <= fs_run;
        trig_ctrl_pkg::frame_one_shot_mode: begin
          // one frame per edge; edges during a frame are dropped
          if (fst_q == fs_frame) begin
            if (frame_done) fst_q <= fs_idle;
          end else if (a_rise) fst_q <= fs_frame;
          else fst_q <= fs_idle;
        end
        trig_ctrl_pkg::acquire_command_mode: begin
          if (a_rise) fst_q <= fs_run;
          else if (fst_q == fs_freeze) fst_q <= fs_idle;
        end
        trig_ctrl_pkg::acquire_command_start_stop_mode: begin
          if (a_rise) fst_q <= fs_run;
          else if (a_fall) fst_q <= fs_freeze;
        end
        trig_ctrl_pkg::start_a_stop_b_mode: begin
          if (b_rise) fst_q <= fs_idle;
          else if (a_rise) fst_q <= fs_run;
        end
        trig_ctrl_pkg::start_a_stop_a_mode: begin
          if (a_rise) fst_q <= fs_run;
          else if (a_fall) fst_q <= fs_idle;
        end
        trig_ctrl_pkg::start_a_stop_a_level_mode: begin
          // frame in progress always finishes; then level decides
          if (fst_q == fs_frame) begin
            if (frame_done && !a_asserted) fst_q <= fs_idle;
          end else if (a_rise || a_asserted) fst_q <= fs_frame;
          else fst_q <= fs_idle;
        end
        trig_ctrl_pkg::continuous_data_mode,
        trig_ctrl_pkg::qualified_continuous_mode: begin
          if (a_rise) fst_q <= fs_run;
        end
        default: fst_q <= fs_idle;
      endcase
    end
  end

  // engine outputs
  logic acq_first_d;
  assign acq_first_d = (fst_q == fs_run) || (fst_q == fs_frame);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_first_q          <= 1'b0;
      frame_acquire_first  <= 1'b0;
      frame_acquire_second <= 1'b0;
      frame_freeze         <= 1'b0;
      data_accept          <= 1'b0;
    end else begin
      acq_first_q         <= acq_first_d;
      frame_acquire_first <= acq_first_d;
      frame_freeze        <= (fst_q == fs_freeze);
      data_accept         <= acq_first_d &&
                             (mode != trig_ctrl_pkg::qualified_continuous_mode ||
                              s.qualifier);
      case (asg)
        trig_ctrl_pkg::engines_shared_trigger:      frame_acquire_second <= acq_first_d;
        trig_ctrl_pkg::engines_split_triggers:      frame_acquire_second <= b_asserted;
        trig_ctrl_pkg::first_triggered_second_free: frame_acquire_second <= 1'b1;
        default:                                    frame_acquire_second <= acq_first_d;
      endcase
    end
  end

  // line encoder source select
  logic enc_lvl;
  always_comb begin
    enc_lvl = 1'b0;
    case (esel)
      trig_ctrl_pkg::enc_ttl:                 enc_lvl = s.enc_ttl;
      trig_ctrl_pkg::enc_diff:                enc_lvl = s.enc_diff;
      trig_ctrl_pkg::enc_opto:                enc_lvl = s.enc_opto;
      trig_ctrl_pkg::enc_engine_zero:         enc_lvl = s.engine_zero_enc;
      trig_ctrl_pkg::enc_timing_gen:          enc_lvl = s.timing_gen;
      trig_ctrl_pkg::enc_button:              enc_lvl = s.button;
      trig_ctrl_pkg::enc_link_trig:           enc_lvl = s.link_trig;
      trig_ctrl_pkg::software_encoder_source: enc_lvl = soft_q[0];
      trig_ctrl_pkg::enc_engine_zero_tgen:    enc_lvl = s.engine_zero_tgen;
      default:                                enc_lvl = 1'b0;
    endcase
  end

  // line gating; one-shot holds the line request until line_done
  logic enc_prev_q;
  logic line_pend_q;
  logic enc_asserted;
  assign enc_asserted = enc_lvl ^ hmode_q[`HMODE_POL_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_prev_q            <= 1'b0;
      line_pend_q           <= 1'b0;
      line_acquire          <= 1'b0;
      encoder_second_enable <= 1'b0;
    end else begin
      enc_prev_q <= enc_asserted;
      // no field enables encoder B, so it stays disabled
      encoder_second_enable <= 1'b0;
      if (lmode == trig_ctrl_pkg::line_one_shot_mode) begin
        if (enc_asserted && !enc_prev_q) line_pend_q <= 1'b1;
        else if (line_done) line_pend_q <= 1'b0;
        line_acquire <= line_pend_q;
      end else begin
        line_pend_q  <= 1'b0;
        line_acquire <= acq_first_q;
      end
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic              do_write;
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_write) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[7:0] <= `REG_STATUS) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; ignore code keeps the select field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vmode_q <= `VMODE_RESET;
      hmode_q <= `HMODE_RESET;
      soft_q  <= 2'h0;
    end else if (do_write) begin
      case (awaddr_q[7:0])
        `REG_VMODE: begin
          vmode_q[7:0]   <= wdata_q[7:0];
          vmode_q[13:12] <= wdata_q[13:12];
          if (wdata_q[`VMODE_SEL_LSB +: 4] != `SEL_IGNORE)
            vmode_q[`VMODE_SEL_LSB +: 4] <= wdata_q[`VMODE_SEL_LSB +: 4];
        end
        `REG_HMODE: begin
          hmode_q[2:0] <= wdata_q[2:0];
          if (wdata_q[`HMODE_SEL_LSB +: 4] != `SEL_IGNORE)
            hmode_q[`HMODE_SEL_LSB +: 4] <= wdata_q[`HMODE_SEL_LSB +: 4];
        end
        `REG_SWTRIG: soft_q <= wdata_q[1:0];
        default: soft_q <= soft_q;
      endcase
    end
  end

  // axi4-lite read path, one cycle to rvalid after arready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[7:0])
          `REG_VMODE:  s_axi_rdata <= vmode_q;
          `REG_HMODE:  s_axi_rdata <= hmode_q;
          `REG_SWTRIG: s_axi_rdata <= {30'h0, soft_q};
          `REG_STATUS: s_axi_rdata <= {24'h0, a_asserted, b_asserted, enc_asserted,
                                       frame_freeze, line_acquire, data_accept,
                                       frame_acquire_second, frame_acquire_first};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> trig_ctrl_checker.sv
// port assertions for the trigger control block, bound onto its top
`timescale 1ns/1ps
module trig_ctrl_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              frame_acquire_first,
  input wire logic              frame_acquire_second,
  input wire logic              frame_freeze,
  input wire logic              data_accept,
  input wire logic              line_acquire,
  input wire logic              encoder_second_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // outputs quiet after reset; checked through reset itself
  AST_RESET_QUIET: assert property (disable iff (1'b0) !aresetn |=> !frame_acquire_first
    && !frame_acquire_second && !frame_freeze && !data_accept && !line_acquire)
    else $error("acquisition output active after reset");
  AST_ENC_B_OFF: assert property (!encoder_second_enable)
    else $error("second encoder enabled");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while response pending");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("no write response");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer one cycle after address");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read ok");
  AST_WR_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr > 8'h0C |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2))
    else $error("unmapped write ok");
  AST_ACCEPT_ACQ: assert property (data_accept |-> frame_acquire_first || $past(frame_acquire_first))
    else $error("data accepted while not acquiring");
  AST_FREEZE_HALT: assert property ($rose(frame_freeze) |-> ##[0:2] !frame_acquire_first)
    else $error("acquisition runs in freeze");

  COV_FREEZE: cover property ($rose(frame_freeze));
  COV_SECOND: cover property ($rose(frame_acquire_second));
  COV_LINE: cover property ($rose(line_acquire));
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind acquisition_trigger_control trig_ctrl_checker #(.ADDR_W(ADDR_W)) chk_i (.*);

// >>> cam_model.sv
// camera side model: ends frames and lines after a programmable length
`timescale 1ns/1ps
module cam_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic [7:0] frame_len,
  input  wire logic       frame_acquire_first,
  input  wire logic       line_acquire,
  output logic            frame_done,
  output logic            line_done
);
  logic [7:0] fcnt_q;
  logic [7:0] lcnt_q;

  // a long length plays a slow camera, a short one a prompt camera
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || !frame_acquire_first || fcnt_q == frame_len)
      fcnt_q <= 8'h00;
    else
      fcnt_q <= fcnt_q + 8'h01;
    frame_done <= aresetn && enable && frame_acquire_first && fcnt_q == frame_len;
  end

  // lines end the same way; done is a one-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || !line_acquire || lcnt_q == frame_len)
      lcnt_q <= 8'h00;
    else
      lcnt_q <= lcnt_q + 8'h01;
    line_done <= aresetn && enable && line_acquire && lcnt_q == frame_len;
  end
endmodule

// >>> tb_top.sv
// self-checking bench for the trigger control block
`timescale 1ns/1ps
`include "trig_ctrl_regs.svh"
module tb_top;
  logic                   aclk;
  logic                   aresetn;
  logic [7:0]             awaddr;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0]            wdata, rdata, d;
  logic [1:0]             bresp, rresp;
  logic [7:0]             araddr;
  logic                   arvalid, arready, rvalid, rready;
  trig_ctrl_pkg::ext_in_t ext_in;
  logic                   frame_done, line_done, cam_en;
  logic [7:0]             frame_len;
  logic [6:0]             outs;
  int                     err_count, check_count, cyc, seed;
  int                     ebit[9] = '{5, 4, 3, 2, 11, 9, 8, 0, 6};

  acquisition_trigger_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_in(ext_in), .frame_done(frame_done), .line_done(line_done),
    .frame_acquire_first(outs[0]), .frame_acquire_second(outs[1]), .frame_freeze(outs[2]),
    .data_accept(outs[3]), .line_acquire(outs[4]), .encoder_second_enable(outs[5]));
  cam_model cam (.aclk(aclk), .aresetn(aresetn), .enable(cam_en), .frame_len(frame_len),
    .frame_acquire_first(outs[0]), .line_acquire(outs[4]), .frame_done(frame_done),
    .line_done(line_done));
  assign outs[6] = frame_done;

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // hang guard, well above the thousand or so cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // write with both beats offered at once; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask

  // bounded wait for an output level, then compare
  task automatic wait_out(input int i, input logic v, input string nm);
    int n;
    n = 0;
    while (outs[i] !== v && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(nm, v, outs[i]);
  endtask

  task automatic hold_out(input int i, input logic v, input string nm);
    logic s;
    s = v;
    repeat (10) begin
      @(posedge aclk);
      if (outs[i] !== v) s = outs[i];
    end
    chk(nm, v, s);
  endtask

  task automatic set_in(input int b, input logic v);
    @(posedge aclk);
    ext_in[b] <= v;
  endtask

  function automatic logic [31:0] vm(input logic [3:0] m, input logic [1:0] asg, input logic pa,
                                     input logic [3:0] s, input logic ca);
    vm = {18'h0, 1'b1, ca, s, 1'b0, pa, asg, m};
  endfunction

  initial begin
    seed = 32'h27c6;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    ext_in = 16'h0000;
    cam_en = 1'b1;
    frame_len = 8'h06 + 8'($unsigned($random(seed)) % 8);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`REG_VMODE, `VMODE_RESET, 2'h0);
    rc(`REG_HMODE, `HMODE_RESET, 2'h0);
    rc(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'hFFFF_FFFF, 2'h2);
    wait_out(0, 1'b1, "free_run_acq");
    set_in(14, 1'b1);
    wr(`REG_SWTRIG, 32'h1, 2'h0);
    hold_out(0, 1'b1, "free_run_ignores");
    hold_out(2, 1'b0, "free_run_no_freeze");
    wr(`REG_SWTRIG, 32'h0, 2'h0);
    set_in(14, 1'b0);
    $display("test reset and free run done");
    for (int m = 0; m < 10; m++) begin
      d = vm(4'(m), 2'($unsigned($random(seed)) % 3), 1'($random(seed)),
             4'($unsigned($random(seed)) % 11), 1'b1);
      wr(`REG_VMODE, d, 2'h0);
      rc(`REG_VMODE, d, 2'h0);
    end
    wr(`REG_VMODE, d | 32'h0000_0F00, 2'h0);
    rc(`REG_VMODE, d, 2'h0);
    for (int m = 0; m < 3; m++) begin
      d = {24'h0, 4'($unsigned($random(seed)) % 9), 1'b0, 1'($random(seed)), 2'(m)};
      wr(`REG_HMODE, d, 2'h0);
      rc(`REG_HMODE, d, 2'h0);
    end
    wr(`REG_HMODE, d | 32'h0000_00F0, 2'h0);
    rc(`REG_HMODE, d, 2'h0);
    $display("test register fields done");
    wr(`REG_VMODE, vm(4'h3, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    set_in(14, 1'b1);
    wait_out(0, 1'b1, "one_shot_start");
    wait_out(0, 1'b0, "one_shot_end");
    hold_out(0, 1'b0, "one_shot_single");
    wr(`REG_VMODE, vm(4'h3, 2'h0, 1'b1, 4'h1, 1'b1), 2'h0);
    hold_out(0, 1'b0, "falling_idle");
    set_in(14, 1'b0);
    wait_out(0, 1'b1, "falling_start");
    wait_out(0, 1'b0, "falling_end");
    wr(`REG_VMODE, vm(4'h3, 2'h0, 1'b0, 4'h1, 1'b0), 2'h0);
    set_in(14, 1'b1);
    hold_out(0, 1'b0, "disconnected");
    set_in(14, 1'b0);
    wr(`REG_SWTRIG, 32'h1, 2'h0);
    wait_out(0, 1'b1, "soft_start");
    wait_out(0, 1'b0, "soft_end");
    wr(`REG_SWTRIG, 32'h2, 2'h0);
    rc(`REG_SWTRIG, 32'h2, 2'h0);
    wr(`REG_SWTRIG, 32'h0, 2'h0);
    $display("test one shot done");
    cam_en <= 1'b0;
    for (int s = 0; s < 11; s++) begin
      if (s == 8) continue;
      wr(`REG_VMODE, vm(4'h7, 2'h0, 1'b0, 4'(s), 1'b1), 2'h0);
      set_in(s < 8 ? 15 - s : 16 - s, 1'b1);
      wait_out(0, 1'b1, "src_start");
      set_in(s < 8 ? 15 - s : 16 - s, 1'b0);
      wait_out(0, 1'b0, "src_stop");
    end
    wr(`REG_VMODE, vm(4'h7, 2'h1, 1'b0, 4'h1, 1'b1), 2'h0);
    set_in(1, 1'b1);
    wait_out(1, 1'b1, "split_second_on");
    set_in(1, 1'b0);
    wait_out(1, 1'b0, "split_second_off");
    wr(`REG_VMODE, vm(4'h7, 2'h2, 1'b0, 4'h1, 1'b1), 2'h0);
    wait_out(1, 1'b1, "second_free");
    wr(`REG_VMODE, vm(4'h7, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    set_in(14, 1'b1);
    wait_out(1, 1'b1, "shared_second");
    set_in(14, 1'b0);
    wr(`REG_VMODE, vm(4'h6, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    set_in(14, 1'b1);
    wait_out(0, 1'b1, "a_b_start");
    set_in(14, 1'b0);
    hold_out(0, 1'b1, "a_b_holds");
    set_in(1, 1'b1);
    wait_out(0, 1'b0, "a_b_stop");
    set_in(1, 1'b0);
    wr(`REG_VMODE, vm(4'h2, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    wr(`REG_SWTRIG, 32'h1, 2'h0);
    wait_out(0, 1'b1, "cmd_start");
    wr(`REG_SWTRIG, 32'h0, 2'h0);
    wait_out(2, 1'b1, "cmd_freeze");
    $display("test start stop done");
    cam_en <= 1'b1;
    wr(`REG_VMODE, vm(4'h8, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    set_in(14, 1'b1);
    wait_out(6, 1'b1, "level_first_frame");
    wait_out(6, 1'b0, "level_gap");
    wait_out(6, 1'b1, "level_second_frame");
    set_in(14, 1'b0);
    wait_out(0, 1'b0, "level_stop");
    wr(`REG_VMODE, vm(4'h9, 2'h0, 1'b0, 4'h1, 1'b1), 2'h0);
    cam_en <= 1'b0;
    set_in(14, 1'b1);
    wait_out(0, 1'b1, "qual_acq");
    hold_out(3, 1'b0, "qual_low");
    set_in(0, 1'b1);
    wait_out(3, 1'b1, "qual_high");
    set_in(0, 1'b0);
    wait_out(3, 1'b0, "qual_drop");
    set_in(14, 1'b0);
    $display("test level and qualified done");
    cam_en <= 1'b1;
    wr(`REG_VMODE, `VMODE_RESET, 2'h0);
    for (int e = 0; e < 9; e++) begin
      if (e == 7) continue;
      wr(`REG_HMODE, {24'h0, 4'(e), 4'h1}, 2'h0);
      set_in(ebit[e], 1'b1);
      wait_out(4, 1'b1, "line_start");
      wait_out(4, 1'b0, "line_end");
      hold_out(4, 1'b0, "line_single");
      set_in(ebit[e], 1'b0);
    end
    set_in(5, 1'b1);
    wr(`REG_HMODE, 32'h0000_0005, 2'h0);
    set_in(5, 1'b0);
    wait_out(4, 1'b1, "line_falling");
    hold_out(5, 1'b0, "enc_second_off");
    wr(`REG_HMODE, 32'h0000_0000, 2'h0);
    wait_out(4, 1'b1, "line_free");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`REG_VMODE, `VMODE_RESET, 2'h0);
    $display("test lines and second reset done");
    end_sim();
  end
endmodule
